// *** hdl/and_exec_core.sv ***
// Four-phase execution core for the literal and register AND instructions.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module and_exec_core (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    output logic             instr_ready,
    output logic             retire,
    input  wire logic [3:0]  bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [15:0] bus_rdata
);

    // ==========================================================
    // State
    and_exec_pkg::qphase_e phase_r;
    and_exec_pkg::qphase_e phase_nxt;
    logic [15:0] ir_r;
    logic        act_r;
    logic [11:0] addr_r;
    logic [7:0]  opnd_r;
    logic [7:0]  res_r;
    logic        res_n_r;
    logic        res_z_r;
    logic [7:0]  w_r;
    logic [3:0]  bank_r;
    logic [11:0] fsr2_r;
    logic        ext_r;
    logic        flag_n_r;
    logic        flag_z_r;
    logic [11:0] maddr_r;
    logic [15:0] rdata_r;
    logic        retire_r;
    logic [7:0]  mem [0:and_exec_pkg::MEM_DEPTH-1];

    // ==========================================================
    // Effective data address for the register form
    function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                             input logic [3:0] bank_select_register, input logic [11:0] fsr,
                                             input logic ext);
        logic [11:0] r;
        r = {bank_select_register, f};
        if (!a) begin
            if (ext && (f <= and_exec_pkg::ILO_MAX)) begin
                r = fsr + {4'h0, f};
            end else if (f < and_exec_pkg::ACCESS_SPLIT) begin
                r = {and_exec_pkg::ACCESS_LO_BK, f};
            end else begin
                r = {and_exec_pkg::ACCESS_HI_BK, f};
            end
        end
        return r;
    endfunction : eff_addr

    // ==========================================================
    // Decode
    wire        is_lit   = act_r && (ir_r[15:8] == and_exec_pkg::OPC_LIT);
    wire        is_reg   = act_r && (ir_r[15:10] == and_exec_pkg::OPC_REG);
    wire        dbit     = ir_r[9];
    wire        abit     = ir_r[8];
    wire [7:0]  fbyte    = ir_r[7:0];
    wire [11:0] op_addr  = eff_addr(fbyte, abit, bank_r, fsr2_r, ext_r);
    wire        q1       = (phase_r == and_exec_pkg::PH_Q1);
    wire        q2       = (phase_r == and_exec_pkg::PH_Q2);
    wire        q3       = (phase_r == and_exec_pkg::PH_Q3);
    wire        q4       = (phase_r == and_exec_pkg::PH_Q4);
    wire        take     = ce && q1 && instr_valid;
    wire        w_from_op = ce && q4 && (is_lit || (is_reg && !dbit));
    wire        mem_we   = ce && q4 && is_reg && dbit;
    wire        flag_we  = ce && q4 && (is_lit || is_reg);
    wire        sw_wr    = ce && bus_wr;
    wire        sw_rd    = ce && bus_rd;
    wire [7:0]  and_res;
    wire        and_neg;
    wire        and_zero;

    assign instr_ready = q1;
    assign retire      = retire_r;
    assign bus_rdata   = rdata_r;

    and_result_unit u_alu (
        .opa    (w_r),
        .opb    (opnd_r),
        .result (and_res),
        .neg    (and_neg),
        .zero   (and_zero)
    );

    // ==========================================================
    // Phase sequencing
    always_comb begin
        unique case (phase_r)
            and_exec_pkg::PH_Q1: phase_nxt = and_exec_pkg::PH_Q2;
            and_exec_pkg::PH_Q2: phase_nxt = and_exec_pkg::PH_Q3;
            and_exec_pkg::PH_Q3: phase_nxt = and_exec_pkg::PH_Q4;
            and_exec_pkg::PH_Q4: phase_nxt = and_exec_pkg::PH_Q1;
        endcase
    end

    // ==========================================================
    // Register read mux
    wire [15:0] rd_mux =
        (bus_addr == and_exec_pkg::OFS_CTRL)   ? {15'h0000, ext_r} :
        (bus_addr == and_exec_pkg::OFS_WREG)   ? {8'h00, w_r} :
        (bus_addr == and_exec_pkg::OFS_BANK)   ? {12'h000, bank_r} :
        (bus_addr == and_exec_pkg::OFS_FSR2)   ? {4'h0, fsr2_r} :
        (bus_addr == and_exec_pkg::OFS_STATUS) ? {11'h000, flag_n_r, 1'b0, flag_z_r, 2'b00} :
        (bus_addr == and_exec_pkg::OFS_MADDR)  ? {4'h0, maddr_r} :
        (bus_addr == and_exec_pkg::OFS_MDATA)  ? {8'h00, mem[maddr_r]} :
        (bus_addr == and_exec_pkg::OFS_EXEC)   ? {12'h000, dbit, is_reg, is_lit, act_r} :
        16'h0000;

    // ==========================================================
    // Instruction pipeline through the four phases
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_r  <= and_exec_pkg::PH_Q1;
            ir_r     <= 16'h0000;
            act_r    <= 1'b0;
            addr_r   <= 12'h000;
            opnd_r   <= 8'h00;
            res_r    <= 8'h00;
            res_n_r  <= 1'b0;
            res_z_r  <= 1'b0;
            retire_r <= 1'b0;
        end else if (ce) begin
            phase_r  <= phase_nxt;
            retire_r <= q4 && (is_lit || is_reg);
            if (q1) begin
                ir_r  <= take ? instr_word : 16'h0000;
                act_r <= take;
            end
            if (q2) begin
                addr_r <= op_addr;
                opnd_r <= is_lit ? fbyte : mem[op_addr];
            end
            if (q3) begin
                res_r   <= and_res;
                res_n_r <= and_neg;
                res_z_r <= and_zero;
            end
        end
    end

    // ==========================================================
    // Architectural registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_r      <= and_exec_pkg::W_RST;
            bank_r   <= and_exec_pkg::BANK_RST;
            fsr2_r   <= and_exec_pkg::FSR2_RST;
            ext_r    <= and_exec_pkg::EXT_RST;
            flag_n_r <= 1'b0;
            flag_z_r <= 1'b0;
            maddr_r  <= 12'h000;
        end else begin
            if (sw_wr && bus_addr == and_exec_pkg::OFS_CTRL) begin
                ext_r <= bus_wdata[and_exec_pkg::CTRL_EXT_BIT];
            end
            if (sw_wr && bus_addr == and_exec_pkg::OFS_BANK) begin
                bank_r <= bus_wdata[3:0];
            end
            if (sw_wr && bus_addr == and_exec_pkg::OFS_FSR2) begin
                fsr2_r <= bus_wdata[11:0];
            end
            if (sw_wr && bus_addr == and_exec_pkg::OFS_MADDR) begin
                maddr_r <= bus_wdata[11:0];
            end
            if (sw_wr && bus_addr == and_exec_pkg::OFS_WREG) begin
                w_r <= bus_wdata[7:0];
            end
            if (w_from_op) begin
                w_r <= res_r;
            end
            if (sw_wr && bus_addr == and_exec_pkg::OFS_STATUS) begin
                flag_n_r <= bus_wdata[and_exec_pkg::STAT_N_BIT];
                flag_z_r <= bus_wdata[and_exec_pkg::STAT_Z_BIT];
            end
            if (flag_we) begin
                flag_n_r <= res_n_r;
                flag_z_r <= res_z_r;
            end
        end
    end

    // ==========================================================
    // Data memory and read port
    always_ff @(posedge clk_sys) begin
        if (sw_wr && bus_addr == and_exec_pkg::OFS_MDATA) begin
            mem[maddr_r] <= bus_wdata[7:0];
        end
        if (mem_we) begin
            mem[addr_r] <= res_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (ce) begin
            rdata_r <= sw_rd ? rd_mux : 16'h0000;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_lit_into_w: assert property (ce && q4 && is_lit |=> w_r == $past(res_r))
        else $error("literal AND result not placed in W");
    a_res_is_and: assert property (ce && q3 && act_r |=> res_r == ($past(w_r) & $past(opnd_r)))
        else $error("result is not the AND of W and operand");
    a_dest_w_only: assert property (ce && q4 && is_reg && !dbit && !sw_wr
        |=> w_r == $past(res_r) && mem[addr_r] == $past(mem[addr_r]))
        else $error("destination 0 did not update W alone");
    a_dest_mem_only: assert property (ce && q4 && is_reg && dbit && !sw_wr
        |=> mem[addr_r] == $past(res_r) && w_r == $past(w_r))
        else $error("destination 1 did not update memory alone");
    a_access_bank: assert property (ce && q2 && is_reg && !abit && !ext_r
        |=> addr_r[11:8] == (fbyte < and_exec_pkg::ACCESS_SPLIT ? and_exec_pkg::ACCESS_LO_BK
                                                               : and_exec_pkg::ACCESS_HI_BK))
        else $error("access bank address wrong");
    a_bank_select: assert property (ce && q2 && is_reg && abit |=> addr_r == {$past(bank_r), $past(fbyte)})
        else $error("bank select not used");
    a_indexed_ofs: assert property (ce && q2 && is_reg && !abit && ext_r
        && fbyte <= and_exec_pkg::ILO_MAX
        |=> addr_r == $past(fsr2_r) + {4'h0, $past(fbyte)})
        else $error("indexed offset address wrong");
    a_flags_follow: assert property (ce && q4 && (is_lit || is_reg)
        |=> flag_n_r == $past(res_r[7]) && flag_z_r == ($past(res_r) == 8'h00))
        else $error("flags do not follow result");
    a_phase_cycle: assert property (ce && q1 |=> q2)
        else $error("phase sequence broken");
    a_phase_hold: assert property (!ce |=> phase_r == $past(phase_r))
        else $error("phase moved with clock enable low");
    a_retire_pulse: assert property (retire && ce |=> !retire)
        else $error("retire longer than one cycle");
    a_read_slot: assert property (ce && !bus_rd |=> bus_rdata == 16'h0000)
        else $error("read data outside its slot");

endmodule : and_exec_core
`default_nettype wire

// *** hdl/and_exec_pkg.sv ***
// Constants and types for the bitwise-AND execution block.
//
// Overview of operation
// - Literal form: W AND literal into W.
// - Register form: W AND addressed memory register.
// - Destination bit 0: result to W.
// - Destination bit 1: result back to register.
// - Access bit 0: address within access bank.
// - Access bit 1: bank select register picks bank.
// - Extended set, access 0, f<=95: indexed offset.
package and_exec_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int MEM_AW = 12;
    localparam int BUS_AW = 4;
    localparam int BUS_DW = 16;
    localparam int MEM_DEPTH = 4096;

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_WREG   = 4'h1;
    localparam logic [3:0] OFS_BANK   = 4'h2;
    localparam logic [3:0] OFS_FSR2   = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MADDR  = 4'h5;
    localparam logic [3:0] OFS_MDATA  = 4'h6;
    localparam logic [3:0] OFS_EXEC   = 4'h7;

    // ==========================================================
    // Field positions
    localparam int CTRL_EXT_BIT   = 0;
    localparam int STAT_N_BIT     = 4;
    localparam int STAT_Z_BIT     = 2;
    localparam int EXEC_ACT_BIT   = 0;
    localparam int EXEC_LIT_BIT   = 1;
    localparam int EXEC_REG_BIT   = 2;
    localparam int EXEC_DEST_BIT  = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  W_RST    = 8'h00;
    localparam logic [3:0]  BANK_RST = 4'h0;
    localparam logic [11:0] FSR2_RST = 12'h000;
    localparam logic        EXT_RST  = 1'b0;

    // ==========================================================
    // Opcodes and addressing
    localparam logic [7:0] OPC_LIT      = 8'h0B;
    localparam logic [5:0] OPC_REG      = 6'h05;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] ILO_MAX      = 8'h5F;
    localparam logic [3:0] ACCESS_LO_BK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BK = 4'hF;

    // ==========================================================
    // Timing
    localparam int PHASES_PER_CYCLE = 4;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} qphase_e;

endpackage : and_exec_pkg

// *** hdl/and_result_unit.sv ***
// Bitwise AND with negative and zero flag generation.
`timescale 1ns/10ps
`default_nettype none
module and_result_unit (
    input  wire logic [7:0] opa,
    input  wire logic [7:0] opb,
    output logic      [7:0] result,
    output logic            neg,
    output logic            zero
);
    assign result = opa & opb;
    assign neg    = result[7];
    assign zero   = (result == 8'h00);
endmodule : and_result_unit
`default_nettype wire

// *** tb/test_logical_and_instruction_exec.sv ***
// Self-checking testbench for the bitwise-AND execution core.
`timescale 1ns/10ps
`default_nettype none
module test_logical_and_instruction_exec;
    // ==========================================================
    // Signals
    logic        clk_sys;
    logic        rst;
    logic        ce;
    logic [15:0] instr_word;
    logic        instr_valid;
    logic        instr_ready;
    logic        retire;
    logic [3:0]  bus_addr;
    logic [15:0] bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [15:0] bus_rdata;
    int          mismatches;
    int          total_checks;

    and_exec_core dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .retire(retire),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata));

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    function automatic logic [15:0] st(input logic [1:0] nz);
        st = 16'h0000;
        st[and_exec_pkg::STAT_N_BIT] = nz[1];
        st[and_exec_pkg::STAT_Z_BIT] = nz[0];
    endfunction : st

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'h1;
        @(posedge clk_sys);
        bus_wr    <= 1'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd   <= 1'h1;
        @(posedge clk_sys);
        bus_rd   <= 1'h0;
        #1;
        chk(what, exp, bus_rdata);
    endtask : reg_rd

    task automatic mem_set(input logic [11:0] a, input logic [7:0] v);
        reg_wr(and_exec_pkg::OFS_MADDR, {4'h0, a});
        reg_wr(and_exec_pkg::OFS_MDATA, {8'h00, v});
    endtask : mem_set

    task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
        reg_wr(and_exec_pkg::OFS_MADDR, {4'h0, a});
        reg_rd(and_exec_pkg::OFS_MDATA, {8'h00, v}, "memory");
    endtask : mem_chk

    task automatic exec(input logic [15:0] word, input logic exp_ret);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (instr_ready !== 1'h1 && n < 8);
        chk_bit("ready wait", 1'h1, instr_ready);
        repeat (4) @(posedge clk_sys);
        instr_word  <= word;
        instr_valid <= 1'h1;
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_bit("retire early", 1'h0, retire);
        @(posedge clk_sys);
        #1;
        chk_bit("retire", exp_ret, retire);
        chk_bit("ready", 1'h1, instr_ready);
        @(posedge clk_sys);
        #1;
        chk_bit("retire pulse", 1'h0, retire);
    endtask : exec

    task automatic lit_case(input logic [7:0] w0, input logic [7:0] k, input logic [7:0] res,
                            input logic [15:0] sx);
        reg_wr(and_exec_pkg::OFS_WREG, {8'h00, w0});
        reg_wr(and_exec_pkg::OFS_STATUS, sx ^ st(2'h3));
        exec({and_exec_pkg::OPC_LIT, k}, 1'h1);
        reg_rd(and_exec_pkg::OFS_WREG, {8'h00, res}, "w");
        reg_rd(and_exec_pkg::OFS_STATUS, sx, "status");
    endtask : lit_case

    task automatic reg_case(input logic [7:0] w0, input logic [11:0] ma, input logic [7:0] mv,
                            input logic d, input logic a, input logic [7:0] f,
                            input logic [7:0] ew, input logic [7:0] em, input logic [15:0] sx);
        mem_set(ma, mv);
        reg_wr(and_exec_pkg::OFS_WREG, {8'h00, w0});
        reg_wr(and_exec_pkg::OFS_STATUS, sx ^ st(2'h3));
        exec({and_exec_pkg::OPC_REG, d, a, f}, 1'h1);
        reg_rd(and_exec_pkg::OFS_WREG, {8'h00, ew}, "w");
        mem_chk(ma, em);
        reg_rd(and_exec_pkg::OFS_STATUS, sx, "status");
    endtask : reg_case

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Tests
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        instr_word = 16'h0000;
        instr_valid = 1'h0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        mismatches = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        reg_rd(and_exec_pkg::OFS_WREG, 16'h0000, "w reset");
        reg_rd(and_exec_pkg::OFS_CTRL, 16'h0000, "ctrl reset");
        reg_rd(4'h9, 16'h0000, "unmapped");
        reg_wr(4'h9, 16'hFFFF);
        reg_rd(4'h9, 16'h0000, "unmapped");
        lit_case(8'hA3, 8'h5F, 8'h03, st(2'h0));
        lit_case(8'h5A, 8'hA5, 8'h00, st(2'h1));
        lit_case(8'h80, 8'hFF, 8'h80, st(2'h2));
        reg_case(8'h17, 12'h020, 8'hC2, 1'h0, 1'h0, 8'h20, 8'h02, 8'hC2, st(2'h0));
        reg_case(8'h3C, 12'hF70, 8'hF0, 1'h1, 1'h0, 8'h70, 8'h3C, 8'h30, st(2'h0));
        reg_wr(and_exec_pkg::OFS_BANK, 16'h0003);
        mem_set(12'h020, 8'h11);
        reg_case(8'h81, 12'h320, 8'hC3, 1'h1, 1'h1, 8'h20, 8'h81, 8'h81, st(2'h2));
        mem_chk(12'h020, 8'h11);
        reg_wr(and_exec_pkg::OFS_CTRL, 16'h0001);
        reg_wr(and_exec_pkg::OFS_FSR2, 16'h0200);
        reg_case(8'h3C, 12'h25F, 8'h0F, 1'h0, 1'h0, 8'h5F, 8'h0C, 8'h0F, st(2'h0));
        reg_case(8'hFF, 12'hF60, 8'h55, 1'h0, 1'h0, 8'h60, 8'h55, 8'h55, st(2'h0));
        reg_case(8'hF0, 12'h305, 8'h0F, 1'h1, 1'h1, 8'h05, 8'hF0, 8'h00, st(2'h1));
        reg_wr(and_exec_pkg::OFS_WREG, 16'h0077);
        exec(16'h0F12, 1'h0);
        reg_rd(and_exec_pkg::OFS_WREG, 16'h0077, "w after other");
        // ==========================================================
        // Clock enable low freezes a software write.
        @(posedge clk_sys);
        ce <= 1'h0;
        reg_wr(and_exec_pkg::OFS_WREG, 16'h00AA);
        ce <= 1'h1;
        reg_rd(and_exec_pkg::OFS_WREG, 16'h0077, "w frozen");
        exec({and_exec_pkg::OPC_LIT, 8'h0F}, 1'h1);
        reg_rd(and_exec_pkg::OFS_WREG, 16'h0007, "w after freeze");
        // ==========================================================
        // Reset in mid-run.
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        #1;
        chk_bit("ready reset", 1'h1, instr_ready);
        chk_bit("retire reset", 1'h0, retire);
        reg_rd(and_exec_pkg::OFS_WREG, 16'h0000, "w reset");
        reg_rd(and_exec_pkg::OFS_STATUS, 16'h0000, "status reset");
        reg_rd(and_exec_pkg::OFS_CTRL, 16'h0000, "ctrl reset");
        lit_case(8'hC4, 8'h84, 8'h84, st(2'h2));
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end
endmodule : test_logical_and_instruction_exec
`default_nettype wire
